/* File: core/sqs_pkg.sv */
// sqs_pkg: constants for the sequencer control decoder, the output
// set/clear register and the sparsification data path.
// assumes a single 10 MHz core clock shared by every user of the package.
package sqs_pkg;

   // control action command word layout
   localparam int CMD_PAT_MSB = 3;
   localparam int CMD_PAT_LSB = 0;
   localparam logic [3:0] CMD_PATTERN = 4'h8;
   localparam int FUNC_MSB = 7;
   localparam int FUNC_LSB = 4;
   localparam int ADDR_MSB = 14;
   localparam int ADDR_LSB = 8;
   localparam int LIST_AW = 7;

   // function codes
   localparam logic [3:0] FN_SET_OUT = 4'h0;
   localparam logic [3:0] FN_DISABLE = 4'h1;
   localparam logic [3:0] FN_RAM_START = 4'h2;
   localparam logic [3:0] FN_RAM_STOP = 4'h3;
   localparam logic [3:0] FN_WAIT_RESUME = 4'h4;
   localparam logic [3:0] FN_CLR_RESUME = 4'h5;
   localparam logic [3:0] FN_SET_SIGNAL = 4'h6;

   // output set/clear register
   localparam int N_LINES = 12;
   localparam int SET_LSB = 0;
   localparam int CLR_LSB = 16;
   localparam int TTL_LSB = 0;
   localparam int ECL_LSB = 4;
   localparam int NIM_LSB = 8;
   localparam int GRP_W = 4;
   localparam logic [N_LINES-1:0] SEQ_OUT_RST = 12'h000;

   // block transfer mode datum
   localparam int MODE_REMAP_BIT = 31;
   localparam int MODE_PED_BIT = 30;
   localparam int MODE_SUB_BIT = 29;

   // pedestal and remap memories
   localparam int MEM_W = 16;
   localparam int MEM_AW = 16;
   localparam int MEM_DEPTH = 65536;

   // reset values of control state
   localparam logic SEQ_EN_RST = 1'b1;
   localparam logic RAM_MODE_RST = 1'b0;
   localparam logic [LIST_AW-1:0] LIST_ADDR_RST = 7'h00;

   // timing: per-word processing budget
   localparam int CLK_PERIOD_NS = 100;
   localparam int PROC_TIME_NS = 50;
   localparam int PROC_CYCLES = (PROC_TIME_NS / CLK_PERIOD_NS < 1) ? 1
                                : PROC_TIME_NS / CLK_PERIOD_NS;
   localparam int PIPE_LATENCY = 2;

endpackage : sqs_pkg

/* File: core/sqs_sequencer_ctrl.sv */
// sqs_sequencer_ctrl: control action decoder, J/K output register and
// on-the-fly pedestal check / remap stage of the readout data path.
// assumes commands and read words come from logic on i_clk; only the
// ecl input 1 pin is asynchronous and is synchronised here.
`timescale 1ns/10ps
`default_nettype none

module sqs_sequencer_ctrl
(
   // clock, reset, enable
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   // control action commands
   input wire logic i_cmd_valid,
   input wire logic [15:0] i_cmd_word,
   input wire logic [31:0] i_cmd_datum,
   output logic o_cmd_ready,
   // sequencer state
   output logic o_seq_enabled,
   output logic o_ram_mode,
   output logic o_list_start,
   output logic [sqs_pkg::LIST_AW-1:0] o_list_start_addr,
   // flags
   input wire logic i_ecl_in1,
   input wire logic i_irq_enable,
   input wire logic i_signal_flag_clr,
   output logic o_list_resume_flag,
   output logic o_list_signal_flag,
   output logic o_irq,
   // front panel lines
   input wire logic [sqs_pkg::N_LINES-1:0] i_host_out,
   output logic [sqs_pkg::GRP_W-1:0] o_ttl_out,
   output logic [sqs_pkg::GRP_W-1:0] o_user_led,
   output logic [sqs_pkg::GRP_W-1:0] o_ecl_out,
   output logic [sqs_pkg::GRP_W-1:0] o_nim_out,
   // memory load from host pointer / data registers
   input wire logic i_mem_we,
   input wire logic [sqs_pkg::MEM_AW-1:0] i_mem_addr,
   input wire logic [sqs_pkg::MEM_W-1:0] i_ped_wdata,
   input wire logic [sqs_pkg::MEM_W-1:0] i_remap_wdata,
   // block transfer setup
   input wire logic i_bt_setup,
   input wire logic [31:0] i_bt_mode,
   // readout data path
   input wire logic i_rd_valid,
   input wire logic [31:0] i_rd_data,
   output logic o_rd_valid,
   output logic [31:0] o_rd_data
);

   // next J/K state for every line at once
   function automatic logic [sqs_pkg::N_LINES-1:0] jk_next(input logic [sqs_pkg::N_LINES-1:0] q,
      input logic [31:0] d);
      logic [sqs_pkg::N_LINES-1:0] s, c;
      s = d[sqs_pkg::SET_LSB +: sqs_pkg::N_LINES];
      c = d[sqs_pkg::CLR_LSB +: sqs_pkg::N_LINES];
      return (s & ~q) | (~c & q);
   endfunction : jk_next
   logic [3:0] func;
   logic pattern_ok, cmd_take, act;
   logic [sqs_pkg::N_LINES-1:0] seq_out_r, lines_r;
   logic seq_en_r, ram_mode_r, list_start_r;
   logic [sqs_pkg::LIST_AW-1:0] list_addr_r;
   logic resume_r, signal_r, irq_r;
   logic ecl_s1_r, ecl_s2_r, ecl_s3_r, ecl_lvl_r, ecl_rise;
   logic remap_en_r, ped_en_r, sub_en_r;
   logic [sqs_pkg::MEM_W-1:0] ped_mem [sqs_pkg::MEM_DEPTH];
   logic [sqs_pkg::MEM_W-1:0] remap_mem [sqs_pkg::MEM_DEPTH];
   logic [sqs_pkg::MEM_W-1:0] ped_q_r, remap_q_r;
   logic s1_valid_r, out_valid_r;
   logic [31:0] s1_data_r, out_data_r;
   logic [16:0] diff;
   logic drop;
   logic [15:0] low_out, high_out;
   // command decode
   assign func = i_cmd_word[sqs_pkg::FUNC_MSB:sqs_pkg::FUNC_LSB];
   assign pattern_ok = (i_cmd_word[sqs_pkg::CMD_PAT_MSB:sqs_pkg::CMD_PAT_LSB]
                        == sqs_pkg::CMD_PATTERN);
   // a wait for the resume flag holds the command until the flag is up
   assign o_cmd_ready = i_ce && !(pattern_ok && func == sqs_pkg::FN_WAIT_RESUME
                                  && !resume_r);
   assign cmd_take = i_cmd_valid && o_cmd_ready;
   // malformed words are consumed but have no effect
   assign act = cmd_take && pattern_ok;

   // output set/clear register
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         seq_out_r <= sqs_pkg::SEQ_OUT_RST;
      else if (act && func == sqs_pkg::FN_SET_OUT)
         seq_out_r <= jk_next(seq_out_r, i_cmd_datum);
   end

   // merged lines, registered so every pin comes from a flip-flop
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         lines_r <= sqs_pkg::SEQ_OUT_RST;
      else if (i_ce)
         lines_r <= seq_out_r | i_host_out;
   end

   assign o_ttl_out = lines_r[sqs_pkg::TTL_LSB +: sqs_pkg::GRP_W];
   assign o_user_led = lines_r[sqs_pkg::TTL_LSB +: sqs_pkg::GRP_W];
   assign o_ecl_out = lines_r[sqs_pkg::ECL_LSB +: sqs_pkg::GRP_W];
   assign o_nim_out = lines_r[sqs_pkg::NIM_LSB +: sqs_pkg::GRP_W];

   // sequencer and list mode control
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         seq_en_r <= sqs_pkg::SEQ_EN_RST;
         ram_mode_r <= sqs_pkg::RAM_MODE_RST;
         list_addr_r <= sqs_pkg::LIST_ADDR_RST;
         list_start_r <= 1'b0;
      end
      else if (i_ce)
      begin
         list_start_r <= 1'b0;
         if (act && func == sqs_pkg::FN_DISABLE)
         begin
            seq_en_r <= 1'b0;
            ram_mode_r <= 1'b0;
         end
         else if (act && func == sqs_pkg::FN_RAM_START)
         begin
            seq_en_r <= 1'b1;
            ram_mode_r <= 1'b1;
            list_addr_r <= i_cmd_word[sqs_pkg::ADDR_MSB:sqs_pkg::ADDR_LSB];
            list_start_r <= 1'b1;
         end
         else if (act && func == sqs_pkg::FN_RAM_STOP)
            ram_mode_r <= 1'b0;
      end
   end

   assign o_seq_enabled = seq_en_r;
   assign o_ram_mode = ram_mode_r;
   assign o_list_start = list_start_r;
   assign o_list_start_addr = list_addr_r;

   // ecl input 1 synchroniser; only s2/s3 feed the edge logic
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         ecl_s1_r <= 1'b0;
         ecl_s2_r <= 1'b0;
         ecl_s3_r <= 1'b0;
         ecl_lvl_r <= 1'b0;
      end
      else if (i_ce)
      begin
         ecl_s1_r <= i_ecl_in1;
         ecl_s2_r <= ecl_s1_r;
         ecl_s3_r <= ecl_s2_r;
         if (ecl_s2_r == ecl_s3_r)
            ecl_lvl_r <= ecl_s3_r;
      end
   end

   assign ecl_rise = (ecl_s2_r == ecl_s3_r) && ecl_s3_r && !ecl_lvl_r;

   // resume flag: an edge in the clearing cycle still sets it
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         resume_r <= 1'b0;
      else if (i_ce)
      begin
         if (ecl_rise)
            resume_r <= 1'b1;
         else if (act && func == sqs_pkg::FN_CLR_RESUME)
            resume_r <= 1'b0;
      end
   end

   // signal flag and interrupt request, set wins over host clear
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         signal_r <= 1'b0;
         irq_r <= 1'b0;
      end
      else if (i_ce)
      begin
         if (act && func == sqs_pkg::FN_SET_SIGNAL)
            signal_r <= 1'b1;
         else if (i_signal_flag_clr)
            signal_r <= 1'b0;
         irq_r <= signal_r && i_irq_enable;
      end
   end

   assign o_list_resume_flag = resume_r;
   assign o_list_signal_flag = signal_r;
   assign o_irq = irq_r;

   // per-transfer processing mode, raw after reset
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         remap_en_r <= 1'b0;
         ped_en_r <= 1'b0;
         sub_en_r <= 1'b0;
      end
      else if (i_ce && i_bt_setup)
      begin
         remap_en_r <= i_bt_mode[sqs_pkg::MODE_REMAP_BIT];
         ped_en_r <= i_bt_mode[sqs_pkg::MODE_PED_BIT];
         sub_en_r <= i_bt_mode[sqs_pkg::MODE_SUB_BIT];
      end
   end

   // memories: host write port, synchronous lookup port
   always_ff @(posedge i_clk)
   begin
      if (i_ce && i_mem_we)
      begin
         ped_mem[i_mem_addr] <= i_ped_wdata;
         remap_mem[i_mem_addr] <= i_remap_wdata;
      end
   end

   // stage 1: both lookups in the same cycle keep remap off the critical path
   always_ff @(posedge i_clk)
   begin
      if (i_ce && i_rd_valid)
      begin
         ped_q_r <= ped_mem[i_rd_data[31:16]];
         remap_q_r <= remap_mem[i_rd_data[31:16]];
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         s1_valid_r <= 1'b0;
         s1_data_r <= 32'h0000_0000;
      end
      else if (i_ce)
      begin
         s1_valid_r <= i_rd_valid;
         if (i_rd_valid)
            s1_data_r <= i_rd_data;
      end
   end

   // stage 2: check, substitute, remap
   assign diff = {1'b0, s1_data_r[15:0]} - {1'b0, ped_q_r};
   always_comb
   begin
      drop = 1'b0;
      low_out = s1_data_r[15:0];
      if (ped_en_r)
      begin
         drop = diff[16];
         if (sub_en_r)
            low_out = diff[15:0];
      end
      high_out = remap_en_r ? remap_q_r : s1_data_r[31:16];
   end
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         out_valid_r <= 1'b0;
         out_data_r <= 32'h0000_0000;
      end
      else if (i_ce)
      begin
         out_valid_r <= s1_valid_r && !drop;
         if (s1_valid_r && !drop)
            out_data_r <= {high_out, low_out};
      end
   end
   assign o_rd_valid = out_valid_r;
   assign o_rd_data = out_data_r;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   sequence s_take(logic [3:0] code);
      i_ce && i_cmd_valid && o_cmd_ready && pattern_ok && func == code;
   endsequence
   sequence s_raw_word;
      (i_ce && i_rd_valid && !ped_en_r && !remap_en_r && !i_bt_setup) ##1
      (i_ce && !i_bt_setup) ##1 i_ce;
   endsequence
   a_bad_pattern_ignored: assert property (
      (cmd_take && !pattern_ok) |=> $stable(seq_out_r) && $stable(seq_en_r)
         && $stable(ram_mode_r) && $stable(signal_r))
      else $error("malformed command changed state");
   a_set_bits_apply: assert property (
      s_take(sqs_pkg::FN_SET_OUT) |=> ((seq_out_r & $past(i_cmd_datum[11:0]
         & ~i_cmd_datum[27:16])) == $past(i_cmd_datum[11:0] & ~i_cmd_datum[27:16])))
      else $error("set bit did not set its line");
   a_clear_bits_apply: assert property (
      s_take(sqs_pkg::FN_SET_OUT) |=> ((seq_out_r & $past(i_cmd_datum[27:16]
         & ~i_cmd_datum[11:0])) == 12'h000))
      else $error("clear bit did not clear its line");
   a_both_toggle: assert property (
      s_take(sqs_pkg::FN_SET_OUT) |=> ((seq_out_r ^ $past(seq_out_r))
         & $past(i_cmd_datum[11:0] & i_cmd_datum[27:16]))
         == $past(i_cmd_datum[11:0] & i_cmd_datum[27:16]))
      else $error("set with clear did not toggle");
   a_disable_all: assert property (
      s_take(sqs_pkg::FN_DISABLE) |=> !o_seq_enabled && !o_ram_mode)
      else $error("disable left sequencer running");
   // a second start right behind the first keeps the pulse up legally
   a_list_start: assert property (
      s_take(sqs_pkg::FN_RAM_START) |=> o_ram_mode && o_list_start
         && o_list_start_addr == $past(i_cmd_word[14:8])
         ##1 (!o_list_start || $past(!i_ce || (act && func == sqs_pkg::FN_RAM_START))))
      else $error("list start address or pulse wrong");
   a_wait_stalls: assert property (
      (i_cmd_word[3:0] == sqs_pkg::CMD_PATTERN && i_cmd_word[7:4] == sqs_pkg::FN_WAIT_RESUME
         && !resume_r) |-> !o_cmd_ready)
      else $error("wait accepted without resume flag");
   a_edge_sets_flag: assert property (
      (i_ce && ecl_rise) |=> o_list_resume_flag)
      else $error("ecl edge did not set resume flag");
   a_reserved_noop: assert property (
      (cmd_take && pattern_ok && func[3] | (func == 4'h7)) |=> $stable(seq_out_r)
         && $stable(seq_en_r) && $stable(ram_mode_r) && $stable(list_addr_r)
         && $stable(signal_r))
      else $error("reserved code had an effect");
   a_lines_or: assert property (
      i_ce |=> lines_r == ($past(seq_out_r) | $past(i_host_out)))
      else $error("output line is not the or of both registers");
   a_raw_passes: assert property (
      s_raw_word |-> o_rd_valid && o_rd_data == $past(i_rd_data, 2))
      else $error("raw word not forwarded unchanged");
   a_sub_drops: assert property (
      (i_ce && s1_valid_r && ped_en_r && sub_en_r && s1_data_r[15:0] < ped_q_r)
         |=> !o_rd_valid)
      else $error("negative difference not suppressed");
   a_thresh_pass: assert property (
      (i_ce && s1_valid_r && ped_en_r && !sub_en_r && !remap_en_r
         && s1_data_r[15:0] >= ped_q_r) |=> o_rd_valid && o_rd_data == $past(s1_data_r))
      else $error("threshold pass altered the word");
endmodule : sqs_sequencer_ctrl

`default_nettype wire

/* File: verif/sqs_host_model.sv */
// sqs_host_model: host cpu side issuing commands, memory loads and setups.
// assumes the bench calls its tasks one at a time and owns i_clk.
`timescale 1ns/10ps
`default_nettype none
module sqs_host_model
(
   // clock and handshake
   input wire logic i_clk,
   input wire logic i_cmd_ready,
   // command port
   output logic o_cmd_valid,
   output logic [15:0] o_cmd_word,
   output logic [31:0] o_cmd_datum,
   // memory load and transfer setup
   output logic o_mem_we,
   output logic [15:0] o_mem_addr,
   output logic [15:0] o_ped_wdata,
   output logic [15:0] o_remap_wdata,
   output logic o_bt_setup,
   output logic [31:0] o_bt_mode
);
   initial
   begin
      {o_cmd_valid, o_mem_we, o_bt_setup} = 3'h0;
      {o_cmd_word, o_cmd_datum, o_mem_addr} = 64'h0;
      {o_ped_wdata, o_remap_wdata, o_bt_mode} = 64'h0;
   end

   // holds the request until ready is seen at an edge; ok low on timeout
   task automatic send_cmd(input logic [3:0] fn, input logic [6:0] a,
                           input logic [31:0] d, input logic [3:0] p, output bit ok);
      bit r;
      ok = 1'b0;
      @(posedge i_clk);
      o_cmd_valid <= 1'b1;
      o_cmd_word <= {1'b0, a, fn, p};
      o_cmd_datum <= d;
      for (int n = 0; n < 200 && !ok; n++)
      begin
         @(negedge i_clk);
         r = i_cmd_ready;
         @(posedge i_clk);
         ok = r;
      end
      o_cmd_valid <= 1'b0;
      // released lines must not keep showing the last value
      o_cmd_word <= ~o_cmd_word;
      o_cmd_datum <= ~o_cmd_datum;
   endtask : send_cmd

   // bench loads every header address before any setup enables processing
   task automatic load_mem(input logic [15:0] a, input logic [15:0] p, input logic [15:0] m);
      @(posedge i_clk);
      o_mem_we <= 1'b1;
      o_mem_addr <= a;
      o_ped_wdata <= p;
      o_remap_wdata <= m;
      @(posedge i_clk);
      o_mem_we <= 1'b0;
      o_ped_wdata <= ~p;
      o_remap_wdata <= ~m;
   endtask : load_mem

   task automatic setup_transfer(input logic [31:0] m);
      @(posedge i_clk);
      o_bt_setup <= 1'b1;
      o_bt_mode <= m;
      @(posedge i_clk);
      o_bt_setup <= 1'b0;
      o_bt_mode <= ~m;
   endtask : setup_transfer
endmodule : sqs_host_model
`default_nettype wire

/* File: verif/sqs_sequencer_ctrl_test.sv */
// sqs_sequencer_ctrl_test: self-checking bench for commands, lines and data path.
// assumes the host model drives the command, memory and setup ports.
`timescale 1ns/10ps
`default_nettype none
module sqs_sequencer_ctrl_test;
   logic i_clk, i_sys_rst, i_ce, i_cmd_valid, o_cmd_ready, o_seq_enabled, o_ram_mode;
   logic o_list_start, i_ecl_in1, i_irq_enable, i_signal_flag_clr, o_list_resume_flag;
   logic o_list_signal_flag, o_irq, i_mem_we, i_bt_setup, i_rd_valid, o_rd_valid;
   logic [15:0] i_cmd_word, i_mem_addr, i_ped_wdata, i_remap_wdata;
   logic [31:0] i_cmd_datum, i_bt_mode, i_rd_data, o_rd_data;
   logic [sqs_pkg::LIST_AW-1:0] o_list_start_addr;
   logic [sqs_pkg::N_LINES-1:0] i_host_out, seq_exp;
   logic [3:0] o_ttl_out, o_user_led, o_ecl_out, o_nim_out;
   logic [31:0] rd_q[$];
   logic [15:0] ped[2] = '{16'h0100, 16'h0100};
   logic [15:0] rmp[2] = '{16'h00AA, 16'h00AB};
   logic [31:0] w[4] = '{32'h1805_0150, 32'h1905_0100, 32'h1805_00FF, 32'h1905_0200};
   logic [31:0] dtab[4] = '{32'h0000_0A53, 32'hF0F3_F0C0, 32'h0FFF_0FFF, 32'h0FFF_0000};
   logic [2:0] mtab[5] = '{3'b011, 3'b010, 3'b111, 3'b100, 3'b000};
   logic [32:0] r;
   int failures, checked, n;
   bit ok;
   localparam logic [3:0] PAT = sqs_pkg::CMD_PATTERN;

   sqs_host_model host (.i_clk, .i_cmd_ready(o_cmd_ready), .o_cmd_valid(i_cmd_valid),
      .o_cmd_word(i_cmd_word), .o_cmd_datum(i_cmd_datum), .o_mem_we(i_mem_we),
      .o_mem_addr(i_mem_addr), .o_ped_wdata(i_ped_wdata), .o_remap_wdata(i_remap_wdata),
      .o_bt_setup(i_bt_setup), .o_bt_mode(i_bt_mode));
   sqs_sequencer_ctrl DUT (.i_clk, .i_sys_rst, .i_ce, .i_cmd_valid, .i_cmd_word,
      .i_cmd_datum, .o_cmd_ready, .o_seq_enabled, .o_ram_mode, .o_list_start,
      .o_list_start_addr, .i_ecl_in1, .i_irq_enable, .i_signal_flag_clr,
      .o_list_resume_flag, .o_list_signal_flag, .o_irq, .i_host_out, .o_ttl_out,
      .o_user_led, .o_ecl_out, .o_nim_out, .i_mem_we, .i_mem_addr, .i_ped_wdata,
      .i_remap_wdata, .i_bt_setup, .i_bt_mode, .i_rd_valid, .i_rd_data, .o_rd_valid,
      .o_rd_data);

   initial
   begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   // kept words collected where they are settled
   always @(negedge i_clk)
      if (o_rd_valid === 1'b1)
         rd_q.push_back(o_rd_data);

   task automatic chk_bit(input string nm, input logic e, input logic g);
      checked++;
      if (g !== e)
      begin
         failures++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_bit

   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_word

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : stop_test

   task automatic cmd(input logic [3:0] fn, input logic [6:0] a, input logic [31:0] d,
                      input logic [3:0] p);
      host.send_cmd(fn, a, d, p, ok);
      if (!ok)
      begin
         failures++;
         stop_test();
      end
   endtask : cmd

   task automatic step(input int k);
      repeat (k) @(posedge i_clk);
      @(negedge i_clk);
   endtask : step

   task automatic chk_lines(input logic [11:0] e);
      chk_word("ttl", e[3:0], o_ttl_out);
      chk_word("led", e[3:0], o_user_led);
      chk_word("ecl", e[7:4], o_ecl_out);
      chk_word("nim", e[11:8], o_nim_out);
   endtask : chk_lines

   task automatic send_rd(input logic [31:0] d);
      @(posedge i_clk);
      i_rd_valid <= 1'b1;
      i_rd_data <= d;
   endtask : send_rd

   task automatic rd_idle;
      @(posedge i_clk);
      i_rd_valid <= 1'b0;
      i_rd_data <= ~i_rd_data;
   endtask : rd_idle

   function automatic logic [11:0] jk(input logic [11:0] q, input logic [31:0] d);
      return (q & ~d[27:16]) | (~q & d[11:0]);
   endfunction : jk

   // {kept, word} for mode {remap, pedestal, subtract}
   function automatic logic [32:0] dp(input logic [2:0] m, input logic [31:0] x);
      logic [15:0] v;
      v = x[15:0];
      if (m[1] && v < ped[x[24]])
         return 33'h0;
      if (m[1] && m[0])
         v = v - ped[x[24]];
      return {1'b1, m[2] ? rmp[x[24]] : x[31:16], v};
   endfunction : dp

   initial
   begin
      i_sys_rst = 1'b1;
      i_ce = 1'b1;
      {i_ecl_in1, i_irq_enable, i_signal_flag_clr, i_rd_valid} = 4'h0;
      i_host_out = 12'h000;
      i_rd_data = 32'h0;
      seq_exp = 12'h000;
      repeat (20) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      step(0);
      chk_bit("enabled_rst", 1'b1, o_seq_enabled);
      chk_bit("ram_mode_rst", 1'b0, o_ram_mode);
      chk_bit("resume_rst", 1'b0, o_list_resume_flag);
      chk_lines(12'h000);
      host.load_mem(16'h1805, ped[0], rmp[0]);
      host.load_mem(16'h1905, ped[1], rmp[1]);
      send_rd(w[2]);
      rd_idle();
      step(1);
      chk_bit("rd_latency", 1'b1, o_rd_valid);
      chk_word("rd_raw", w[2], o_rd_data);
      foreach (mtab[k])
      begin
         host.setup_transfer({mtab[k], 29'h0});
         rd_q.delete();
         foreach (w[j])
            send_rd(w[j]);
         rd_idle();
         step(3);
         n = 0;
         foreach (w[j])
         begin
            r = dp(mtab[k], w[j]);
            if (r[32])
            begin
               chk_word("rd_data", r[31:0], (n < rd_q.size()) ? rd_q[n] : 32'hX);
               n++;
            end
         end
         chk_word("rd_count", n, rd_q.size());
      end
      @(posedge i_clk);
      i_ce <= 1'b0;
      i_host_out <= 12'h104;
      step(2);
      chk_lines(12'h000);
      chk_bit("ce_ready", 1'b0, o_cmd_ready);
      @(posedge i_clk);
      i_ce <= 1'b1;
      foreach (dtab[k])
      begin
         cmd(sqs_pkg::FN_SET_OUT, 7'h00, dtab[k], PAT);
         seq_exp = jk(seq_exp, dtab[k]);
         step(1);
         chk_lines(seq_exp | 12'h104);
      end
      for (int f = 7; f < 16; f++)
         cmd(f[3:0], 7'h55, 32'h0000_0FFF, PAT);
      cmd(sqs_pkg::FN_RAM_START, 7'h33, 32'h0000_0FFF, 4'h0);
      cmd(sqs_pkg::FN_SET_OUT, 7'h00, 32'h0000_0FFF, 4'hC);
      step(1);
      chk_lines(12'h104);
      chk_bit("ram_mode_rsv", 1'b0, o_ram_mode);
      chk_word("addr_rsv", 7'h00, o_list_start_addr);
      chk_bit("signal_rsv", 1'b0, o_list_signal_flag);
      cmd(sqs_pkg::FN_RAM_START, 7'h2A, 32'h0, PAT);
      step(0);
      chk_bit("list_start", 1'b1, o_list_start);
      chk_bit("ram_mode_on", 1'b1, o_ram_mode);
      chk_word("start_addr", 7'h2A, o_list_start_addr);
      step(0);
      chk_bit("list_start_end", 1'b0, o_list_start);
      cmd(sqs_pkg::FN_RAM_STOP, 7'h7F, 32'hFFFF_FFFF, PAT);
      step(0);
      chk_bit("ram_mode_off", 1'b0, o_ram_mode);
      chk_bit("enabled_kept", 1'b1, o_seq_enabled);
      cmd(sqs_pkg::FN_DISABLE, 7'h00, 32'hFFFF_FFFF, PAT);
      step(1);
      chk_bit("disabled", 1'b0, o_seq_enabled);
      chk_lines(12'h104);
      cmd(sqs_pkg::FN_RAM_START, 7'h7F, 32'h0, PAT);
      step(0);
      chk_bit("reenabled", 1'b1, o_seq_enabled);
      chk_word("start_addr_max", 7'h7F, o_list_start_addr);
      fork
         host.send_cmd(sqs_pkg::FN_WAIT_RESUME, 7'h00, 32'h0, PAT, ok);
         begin
            step(3);
            chk_bit("wait_stall", 1'b0, o_cmd_ready);
            @(posedge i_clk);
            i_ecl_in1 <= 1'b1;
         end
      join
      chk_bit("wait_done", 1'b1, ok);
      if (!ok)
         stop_test();
      step(0);
      chk_bit("resume_set", 1'b1, o_list_resume_flag);
      cmd(sqs_pkg::FN_CLR_RESUME, 7'h00, 32'h0, PAT);
      step(0);
      chk_bit("resume_clr", 1'b0, o_list_resume_flag);
      @(posedge i_clk);
      i_irq_enable <= 1'b1;
      cmd(sqs_pkg::FN_SET_SIGNAL, 7'h00, 32'h0, PAT);
      step(0);
      chk_bit("signal_set", 1'b1, o_list_signal_flag);
      step(0);
      chk_bit("irq_on", 1'b1, o_irq);
      @(posedge i_clk);
      i_signal_flag_clr <= 1'b1;
      i_irq_enable <= 1'b0;
      @(posedge i_clk);
      i_signal_flag_clr <= 1'b0;
      step(1);
      chk_bit("signal_clr", 1'b0, o_list_signal_flag);
      cmd(sqs_pkg::FN_SET_SIGNAL, 7'h00, 32'h0, PAT);
      step(1);
      chk_bit("irq_masked", 1'b0, o_irq);
      stop_test();
   end
endmodule : sqs_sequencer_ctrl_test
`default_nettype wire
